// ===== rtl/opc_top.sv
/*
 * Oscillator and PLL configuration block with an AXI4-Lite slave.
 * Assumes straps and source pin are asynchronous board levels and that
 * the analog PLL macro relocks within the relock hold time.
 */
// What the document requires of this block, the board and software
// RULE_01: grounded select pin picks external resonator
// RULE_02: slow oscillator tick keeps real-time counter alive
// RULE_03: analog node clocked straight from oscillator
// RULE_04: pll output feeds switch, tile, reference
// RULE_05: straps 00 and 11 give default settings
// RULE_06: straps 10 and 01 give default settings
// RULE_07: tile clock from osc, multiplier, dividers
// RULE_08: software keeps fields and vco in range
// RULE_09: software overrides pll settings at run time
// RULE_10: straps held static until third edge
// RULE_11: 32-bit timer ticks every 10 ns
// RULE_12: long internal reset sequence before boot
// RULE_13: clocks held quiet until pll relocks
`timescale 1ns/1ps
`include "opc_consts.svh"

module opc_top #(
    parameter int BOOT_CYCLES   = `OPC_BOOT_CYCLES,
    parameter int RELOCK_CYCLES = `OPC_RELOCK_CYCLES,
    parameter int LP_TICK       = `OPC_LP_TICK_CYCLES
) (
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // board pins
    input  wire logic                      osc_source_select_n,
    input  wire logic                      freq_range_strap0,
    input  wire logic                      freq_range_strap1,
    // axi4-lite write
    input  wire logic [`OPC_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // axi4-lite read
    input  wire logic [`OPC_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // clock control
    output opc_pkg::opc_pll_cfg_type       pll_cfg,
    output logic                           osc_internal_sel,
    output logic                           analog_clk_from_osc,
    output logic                           hs_clk_en,
    output logic                           boot_done,
    output logic                           lp_rtc_tick,
    output logic                           ref_tick,
    output logic [31:0]                    timer_value
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic opc_pkg::opc_pll_cfg_type strap_default(
        input logic [1:0] code);
        opc_pkg::opc_pll_cfg_type c;
        c.r = `OPC_R_DEFAULT;
        c.od = `OPC_OD_OTHER;
        unique case (code)
            2'h0: begin
                c.od = `OPC_OD_CODE00;              // RULE_05
                c.f  = `OPC_F_CODE00;
            end
            2'h3: c.f = `OPC_F_CODE11;              // RULE_05
            2'h2: c.f = `OPC_F_CODE10;              // RULE_06
            2'h1: c.f = `OPC_F_CODE01;              // RULE_06
        endcase
        return c;
    endfunction

    function automatic logic [31:0] cfg_word(
        input opc_pkg::opc_pll_cfg_type c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`OPC_F_LSB +: `OPC_F_W]   = c.f;
        w[`OPC_R_LSB +: `OPC_R_W]   = c.r;
        w[`OPC_OD_LSB +: `OPC_OD_W] = c.od;
        return w;
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;

    always_ff @(posedge aclk) begin
        pin_meta_reg <= {osc_source_select_n, freq_range_strap1,
                         freq_range_strap0};
        pin_sync_reg <= pin_meta_reg;
    end

    // ------------------------------------------------------------------
    // sequence: strap capture, internal reset, run, relock
    // ------------------------------------------------------------------
    localparam int CNT_W = 20;
    localparam int RELOCK_LAST = RELOCK_CYCLES - 1;
    localparam int BOOT_LAST   = BOOT_CYCLES - 1;

    opc_pkg::opc_state_type state_reg;
    logic [CNT_W-1:0]       cnt_reg;
    logic [1:0]             strap_code_reg;
    logic                   cfg_write;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= opc_pkg::ST_STRAP;
            cnt_reg   <= '0;
        end else begin
            unique case (state_reg)
                opc_pkg::ST_STRAP: begin
                    // straps are static through the third edge
                    if (cnt_reg == CNT_W'(`OPC_STRAP_EDGE - 1)) begin
                        state_reg <= opc_pkg::ST_BOOT;   // RULE_10
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                opc_pkg::ST_BOOT: begin
                    if (cnt_reg == CNT_W'(BOOT_LAST)) begin
                        state_reg <= opc_pkg::ST_RUN;    // RULE_12
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                opc_pkg::ST_RUN: begin
                    if (cfg_write) begin
                        state_reg <= opc_pkg::ST_RELOCK; // RULE_13
                        cnt_reg   <= '0;
                    end
                end
                opc_pkg::ST_RELOCK: begin
                    // a further write restarts the hold
                    if (cfg_write) begin
                        cnt_reg <= '0;                   // RULE_13
                    end else if (cnt_reg == CNT_W'(RELOCK_LAST)) begin
                        state_reg <= opc_pkg::ST_RUN;
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_clk_en <= 1'b0;
            boot_done <= 1'b0;
        end else begin
            hs_clk_en <= (state_reg == opc_pkg::ST_RUN) && !cfg_write;
            if (state_reg == opc_pkg::ST_RUN) begin
                boot_done <= 1'b1;                       // RULE_12
            end
        end
    end

    // ------------------------------------------------------------------
    // strap capture and pll configuration
    // ------------------------------------------------------------------
    logic [31:0] cfg_merged;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_code_reg      <= 2'h0;
            osc_internal_sel    <= 1'b0;
            analog_clk_from_osc <= 1'b0;
            pll_cfg             <= strap_default(2'h0);
        end else if (state_reg == opc_pkg::ST_STRAP &&
                     cnt_reg == CNT_W'(`OPC_STRAP_EDGE - 1)) begin
            strap_code_reg      <= pin_sync_reg[1:0];    // RULE_10
            osc_internal_sel    <= pin_sync_reg[2];      // RULE_01
            analog_clk_from_osc <= 1'b1;                 // RULE_03
            pll_cfg             <= strap_default(pin_sync_reg[1:0]);
        end else if (cfg_write) begin
            // fields are stored as written, with no check against the legal ranges
            pll_cfg.f  <= cfg_merged[`OPC_F_LSB +: `OPC_F_W];    // RULE_09
            pll_cfg.r  <= cfg_merged[`OPC_R_LSB +: `OPC_R_W];    // RULE_08
            pll_cfg.od <= cfg_merged[`OPC_OD_LSB +: `OPC_OD_W];  // RULE_07
        end
    end

    // ------------------------------------------------------------------
    // reference tick, processor timer, low-power tick
    // ------------------------------------------------------------------
    localparam int ACC_W = 15;
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_sum;
    logic [12:0]      lp_cnt_reg;

    assign acc_sum = acc_reg + ACC_W'(`OPC_CLK_PERIOD_PS);

    // 10 ns is 2.5 bus cycles, so ticks alternate 2 and 3 cycles apart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_reg     <= '0;
            ref_tick    <= 1'b0;
            timer_value <= 32'h0000_0000;
        end else begin
            ref_tick <= 1'b0;
            if (hs_clk_en) begin                          // RULE_04
                if (acc_sum >= ACC_W'(`OPC_REF_TICK_PS)) begin
                    acc_reg     <= acc_sum - ACC_W'(`OPC_REF_TICK_PS);
                    ref_tick    <= 1'b1;
                    timer_value <= timer_value + 32'h0000_0001; // RULE_11
                end else begin
                    acc_reg <= acc_sum;
                end
            end
        end
    end

    // runs regardless of the pll, as the slow oscillator would
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lp_cnt_reg  <= '0;
            lp_rtc_tick <= 1'b0;
        end else if (lp_cnt_reg == 13'(LP_TICK - 1)) begin
            lp_cnt_reg  <= '0;
            lp_rtc_tick <= 1'b1;                          // RULE_02
        end else begin
            lp_cnt_reg  <= lp_cnt_reg + 1'b1;
            lp_rtc_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------
    logic                   aw_held_reg;
    logic                   w_held_reg;
    logic [`OPC_ADDR_W-1:0] awaddr_reg;
    logic [31:0]            wdata_reg;
    logic [3:0]             wstrb_reg;
    logic                   wr_go;
    logic [31:0]            cfg_now;

    assign wr_go     = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign cfg_write = wr_go && (awaddr_reg == `OPC_PLL_CFG_OFS);
    assign cfg_now   = cfg_word(pll_cfg);

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cfg_merged[i*8 +: 8] = wstrb_reg[i] ? wdata_reg[i*8 +: 8]
                                                : cfg_now[i*8 +: 8];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            awaddr_reg    <= '0;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready;
            s_axi_wready  <= !w_held_reg && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg   <= 1'b1;
                awaddr_reg    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg   <= 1'b1;
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_reg == `OPC_PLL_CFG_OFS ||
                                 awaddr_reg == `OPC_STATUS_OFS ||
                                 awaddr_reg == `OPC_TIMER_OFS)
                                ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            unique case (s_axi_araddr)
                `OPC_PLL_CFG_OFS: s_axi_rdata <= cfg_now;
                `OPC_STATUS_OFS:  s_axi_rdata <= {26'h0, osc_internal_sel,
                                      strap_code_reg, hs_clk_en,
                                      boot_done, analog_clk_from_osc};
                `OPC_TIMER_OFS:   s_axi_rdata <= timer_value;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// ===== rtl/opc_consts.svh
/*
 * Offsets, field positions, reset values and timing figures of the
 * oscillator and PLL configuration block.
 * Assumes a 250 MHz bus clock; included by bare name.
 */
`ifndef OPC_CONSTS_SVH
`define OPC_CONSTS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define OPC_ADDR_W          8
`define OPC_PLL_CFG_OFS     8'h00
`define OPC_STATUS_OFS      8'h04
`define OPC_TIMER_OFS       8'h08

// ----------------------------------------------------------------------
// pll configuration fields
// ----------------------------------------------------------------------
`define OPC_F_LSB           0
`define OPC_F_W             12
`define OPC_R_LSB           12
`define OPC_R_W             6
`define OPC_OD_LSB          20
`define OPC_OD_W            3

// ----------------------------------------------------------------------
// strap defaults: output divider, feedback multiplier, input divider
// ----------------------------------------------------------------------
`define OPC_OD_CODE00       3'h1
`define OPC_F_CODE00        12'h07A
`define OPC_OD_OTHER        3'h2
`define OPC_F_CODE11        12'h077
`define OPC_F_CODE10        12'h031
`define OPC_F_CODE01        12'h017
`define OPC_R_DEFAULT       6'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define OPC_CLK_HZ          250000000
`define OPC_CLK_PERIOD_PS   4000
`define OPC_REF_TICK_NS     10
`define OPC_REF_TICK_PS     (`OPC_REF_TICK_NS * 1000)
`define OPC_LP_OSC_HZ       31250
`define OPC_LP_TICK_CYCLES  (`OPC_CLK_HZ / `OPC_LP_OSC_HZ)
`define OPC_INT_OSC_MHZ     20
`define OPC_STRAP_EDGE      3
`define OPC_BOOT_CYCLES     750000
`define OPC_RELOCK_CYCLES   256

`endif

// ===== rtl/opc_pkg.sv
/*
 * Types of the oscillator and PLL configuration block.
 * Assumes opc_consts.svh for field widths.
 */
`include "opc_consts.svh"

package opc_pkg;

    typedef struct packed {
        logic [`OPC_OD_W-1:0] od;
        logic [`OPC_F_W-1:0]  f;
        logic [`OPC_R_W-1:0]  r;
    } opc_pll_cfg_type;

    typedef enum logic [1:0] {
        ST_STRAP,
        ST_BOOT,
        ST_RUN,
        ST_RELOCK
    } opc_state_type;

endpackage

// ===== tb/opc_board_model.sv
/*
 * Board model: strap pins and oscillator source pin.
 * Assumes the bench chooses the strapping while reset is held.
 */
`timescale 1ns/1ps

module opc_board_model (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // strapping chosen by the bench
    input  wire logic [1:0] brd_code,
    input  wire logic       brd_int,
    // pins
    output logic            osc_source_select_n,
    output logic            freq_range_strap0,
    output logic            freq_range_strap1
);
    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // re-strapped only in reset, so pins stay static past the
    // third edge after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_source_select_n <= brd_int;
            freq_range_strap0   <= brd_code[0];
            freq_range_strap1   <= brd_code[1];
        end
    end
endmodule

// ===== tb/opc_top_assertions.sv
/*
 * Checker for the clock configuration block.
 * Assumes binding to opc_top with its parameters.
 */
`timescale 1ns/1ps

module opc_top_assertions #(
    parameter int BOOT_CYCLES   = 750000,
    parameter int RELOCK_CYCLES = 256,
    parameter int LP_TICK       = 8000
) (
    // clock and reset
    input wire logic                aclk,
    input wire logic                aresetn,
    // board pins
    input wire logic                osc_source_select_n,
    input wire logic                freq_range_strap0,
    input wire logic                freq_range_strap1,
    // clock control
    input opc_pkg::opc_pll_cfg_type pll_cfg,
    input wire logic                osc_internal_sel,
    input wire logic                analog_clk_from_osc,
    input wire logic                hs_clk_en,
    input wire logic                boot_done,
    input wire logic                lp_rtc_tick,
    input wire logic                ref_tick,
    input wire logic [31:0]         timer_value
);
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    logic [31:0] rel_cnt;
    logic [31:0] low_cnt;
    logic [31:0] lp_cnt;
    logic        lp_seen;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rel_cnt <= 32'h0;
            low_cnt <= 32'h0;
            lp_cnt  <= 32'h0;
            lp_seen <= 1'b0;
        end else begin
            rel_cnt <= rel_cnt + 32'h1;
            low_cnt <= hs_clk_en ? 32'h0 : low_cnt + 32'h1;
            lp_cnt  <= lp_rtc_tick ? 32'h0 : lp_cnt + 32'h1;
            lp_seen <= lp_seen | lp_rtc_tick;
        end
    end

    function automatic opc_pkg::opc_pll_cfg_type dflt(
        input logic [1:0] c);
        case (c)
            2'b00:   return '{3'h1, 12'h07A, 6'h00};
            2'b11:   return '{3'h2, 12'h077, 6'h00};
            2'b10:   return '{3'h2, 12'h031, 6'h00};
            default: return '{3'h2, 12'h017, 6'h00};
        endcase
    endfunction

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_osc_select: assert property (
        boot_done |-> osc_internal_sel == osc_source_select_n)
        else $error("oscillator choice differs from pin");
    a_lp_period: assert property (
        lp_rtc_tick && lp_seen |-> lp_cnt == LP_TICK - 1)
        else $error("slow tick period wrong");
    a_analog_direct: assert property (
        boot_done |-> analog_clk_from_osc)
        else $error("analog clock not from oscillator");
    a_tick_gated: assert property (
        ref_tick |-> $past(hs_clk_en))
        else $error("reference tick without pll clock");
    a_strap_dflt: assert property (
        $rose(boot_done) |->
        pll_cfg == dflt({freq_range_strap1, freq_range_strap0}))
        else $error("strap defaults wrong");
    a_tick_gap: assert property (
        ref_tick ##1 (hs_clk_en && !ref_tick)[*2]
        |=> ref_tick || !hs_clk_en)
        else $error("reference tick gap too long");
    a_tick_min: assert property (ref_tick |=> !ref_tick)
        else $error("reference ticks back to back");
    a_timer_step: assert property (
        1'b1 |=> timer_value - $past(timer_value) <= 32'h1)
        else $error("timer jumped");
    a_boot_len: assert property (
        $rose(boot_done) |-> rel_cnt >= BOOT_CYCLES
        && rel_cnt <= BOOT_CYCLES + 12)
        else $error("boot sequence length wrong");
    a_relock_drop: assert property (
        $changed(pll_cfg) && $past(hs_clk_en) |-> !hs_clk_en)
        else $error("clocks not held on new settings");
    a_relock_len: assert property (
        $rose(hs_clk_en) && $past(boot_done) |->
        $past(low_cnt) + 2 >= RELOCK_CYCLES
        && $past(low_cnt) <= RELOCK_CYCLES + 1)
        else $error("relock hold length wrong");

    c_boot: cover property ($rose(boot_done));
    c_relock: cover property ($rose(hs_clk_en) && $past(boot_done));
    c_lp: cover property (lp_rtc_tick && lp_seen);
endmodule

// ===== tb/tb_osc_pll_clock_config.sv
/*
 * Bench for the clock configuration block over AXI4-Lite.
 * Assumes the board model straps pins during reset.
 */
`timescale 1ns/1ps

module tb_osc_pll_clock_config;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [1:0] brd_code = 2'h0;
    logic brd_int = 1'b0;
    logic osc_source_select_n, freq_range_strap0, freq_range_strap1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, timer_value;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, osc_internal_sel, analog_clk_from_osc;
    logic hs_clk_en, boot_done, lp_rtc_tick, ref_tick;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    opc_pkg::opc_pll_cfg_type pll_cfg;
    int fails = 0;
    int num_checks = 0;

    // short counts keep the run brief
    opc_top #(.BOOT_CYCLES(20), .RELOCK_CYCLES(4), .LP_TICK(10))
        opc_top_i (.*);
    opc_board_model opc_board_model_i (.*);

    initial begin
        forever #2 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    function automatic logic [31:0] dflt(input logic [1:0] c);
        case (c)
            2'b00:   return 32'h0010_007A;
            2'b11:   return 32'h0020_0077;
            2'b10:   return 32'h0020_0031;
            default: return 32'h0020_0017;
        endcase
    endfunction

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [31:0] t0;
        logic [1:0] r;
        int n;
        for (int c = 0; c < 4; c++) begin
            brd_code <= c[1:0];
            brd_int <= c[0];
            aresetn <= 1'b0;
            repeat (6) @(posedge aclk);
            aresetn <= 1'b1;
            for (n = 0; n < 200 && boot_done !== 1'b1; n++)
                @(posedge aclk);
            chk(boot_done, 1);
            rd(8'h00, d, r);
            chk(d, dflt(c[1:0]));
            rd(8'h04, d, r);
            chk(d, {26'h0, c[0], c[1:0], 3'b111});
        end
        // in-range fields: od 3, r 5, f 255
        wr(8'h00, 32'h0030_50FF, r);
        chk(r, 2'b00);
        #1;
        chk(hs_clk_en, 0);
        chk(pll_cfg, {3'h3, 12'h0FF, 6'h05});
        for (n = 0; n < 20 && hs_clk_en !== 1'b1; n++)
            @(posedge aclk);
        chk(hs_clk_en, 1);
        rd(8'h00, d, r);
        chk(d, 32'h0030_50FF);
        t0 = timer_value;
        repeat (25) @(posedge aclk);
        d = timer_value - t0;
        chk(d >= 9 && d <= 11, 1);
        n = 0;
        repeat (100) begin
            @(posedge aclk);
            n += lp_rtc_tick;
        end
        chk(n, 10);
        rd(8'h0C, d, r);
        chk(r, 2'b10);
        chk(d, 32'h0);
        wr(8'h04, 32'hFFFF_FFFF, r);
        chk(r, 2'b00);
        rd(8'h04, d, r);
        chk(r, 2'b00);
        chk(d, 32'h0000_003F);
        wr(8'h10, 32'h0, r);
        chk(r, 2'b10);
        finish_test;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        finish_test;
    end
endmodule

bind opc_top opc_top_assertions #(
    .BOOT_CYCLES(BOOT_CYCLES),
    .RELOCK_CYCLES(RELOCK_CYCLES),
    .LP_TICK(LP_TICK)
) opc_top_assertions_i (.*);
